// ===== rtl/pcrc_top.sv
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - FIFO is 8 words deep when length field exceeds 7, else 16.
// - Write covering the top data bit raises the word count by one.
// - Shifting starts with shift_start set and runs while count is above zero.
// - Each finished word lowers the count; shifting runs until zero.
// - One bit per clock: length+1 cycles per queued word.
// - Full flag set when count equals the FIFO depth.
// - Empty flag set when the count is zero.
// - Write while full wraps count to zero; no event for that.
// - Count going from one to zero pulses the event output.
// - Sleep freezes the shifter in its state; it resumes afterwards.
// - With stop_in_idle set, idle acts as sleep; else it runs on.
// - Count field at control bits 12-8 reports queued words.
// - Clearing shift_start stops the shifter only once FIFO is empty.
// - Control bits 3-0 hold polynomial length minus one.
// - Tap bit n enables feedback at term n; bit 0 reads zero.
// - Zero-order term and top term always apply.
module pcrc_top
    import pcrc_pkg::*;
#(
    parameter int FIFO_MAX = 16
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic        sleep_mode,
    input  wire logic        idle_mode,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             crc_event,
    output logic             fifo_full_flag,
    output logic             fifo_empty_flag
);
    import pcrc_pkg::*;

    // --------------------------------------------------------------
    // Elaboration check
    // --------------------------------------------------------------
    // Count field and depth decode are built for a 16-word array
    if (FIFO_MAX != 16)
    begin : g_bad_depth
        $error("pcrc_top: FIFO_MAX must be 16");
    end

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    logic [15:0] fifo_mem [FIFO_MAX];
    logic [3:0]  wr_ptr_q;
    logic [3:0]  rd_ptr_q;
    logic [4:0]  cnt_q;
    logic [4:0]  cnt_d;
    logic [3:0]  bit_idx_q;
    logic [3:0]  poly_len_minus_one;
    logic [15:0] crc_polynomial_taps;
    logic        shift_start;
    logic        stop_in_idle;
    logic        shifter_on_q;
    logic [15:0] crc_q;
    logic        rd_ph_q;

    // --------------------------------------------------------------
    // APB decode
    // --------------------------------------------------------------
    // Setup cycle loads the answer so pready and prdata come from flops
    wire setup     = psel && !penable;
    wire access    = psel && penable && pready;
    wire wr_acc    = access && pwrite;
    wire hit_ctl   = (paddr == ADDR_CONTROL);
    wire hit_taps  = (paddr == ADDR_TAPS);
    wire hit_data  = (paddr == ADDR_DATA);
    wire hit_seed  = (paddr == ADDR_SEED);
    wire mapped    = hit_ctl || hit_taps || hit_data || hit_seed;
    wire wr_ctl    = wr_acc && hit_ctl;
    wire wr_taps   = wr_acc && hit_taps;
    wire wr_data   = wr_acc && hit_data;
    wire wr_seed   = wr_acc && hit_seed;

    // --------------------------------------------------------------
    // FIFO sizing and flags
    // --------------------------------------------------------------
    wire [4:0] depth = (poly_len_minus_one > PLEN_SHORT) ? DEPTH_LONG
                                                         : DEPTH_SHORT;
    wire       full_now  = (cnt_q == depth);
    wire       empty_now = (cnt_q == 5'h00);

    // Top data bit lies in byte 1 for lengths above 8 bits
    wire msb_lane = (poly_len_minus_one > PLEN_SHORT) ? pstrb[1]
                                                      : pstrb[0];
    wire push     = wr_data && msb_lane && !full_now;
    wire wrap     = wr_data && msb_lane && full_now;

    // --------------------------------------------------------------
    // Shifter control
    // --------------------------------------------------------------
    // Sleep, or idle with stop_in_idle, holds every shifting flop
    wire run_en   = !(sleep_mode || (idle_mode && stop_in_idle));
    wire shift_en = run_en && shifter_on_q && !empty_now;
    wire pop      = shift_en && (bit_idx_q == 4'h0);
    wire cur_bit  = fifo_mem[rd_ptr_q][bit_idx_q];

    // Net count change; a wrapping write overrides everything
    assign cnt_d = wrap ? 5'h00
                 : (push && !pop) ? cnt_q + 5'h01
                 : (pop && !push) ? cnt_q - 5'h01
                 : cnt_q;

    // --------------------------------------------------------------
    // Register read mux
    // --------------------------------------------------------------
    wire [15:0] ctl_rd = {2'b00, stop_in_idle, cnt_q, full_now, empty_now,
                          1'b0, shift_start, poly_len_minus_one};
    wire [31:0] rd_mux = hit_ctl  ? {16'h0000, ctl_rd}
                       : hit_taps ? {16'h0000, crc_polynomial_taps}
                       : (hit_data || hit_seed) ? {16'h0000, crc_q}
                       : 32'h0000_0000;

    // --------------------------------------------------------------
    // APB response flops
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            rd_ph_q <= 1'b0;
        end
        else
        begin
            pready  <= setup;
            prdata  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
            pslverr <= setup && !mapped;
            rd_ph_q <= setup && !pwrite;
        end
    end

    // --------------------------------------------------------------
    // Control and tap registers
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            poly_len_minus_one  <= PLEN_RST;
            shift_start         <= 1'b0;
            stop_in_idle        <= 1'b0;
            crc_polynomial_taps <= TAPS_RST;
        end
        else
        begin
            if (wr_ctl && pstrb[0])
            begin
                poly_len_minus_one <= pwdata[CTL_PLEN_LSB +: 4];
                shift_start        <= pwdata[CTL_GO_BIT];
            end
            if (wr_ctl && pstrb[1])
                stop_in_idle <= pwdata[CTL_IDLE_BIT];
            if (wr_taps)
                crc_polynomial_taps <= pwdata[15:0] & TAPS_MASK;
        end
    end

    // --------------------------------------------------------------
    // Shifter enable latch
    // --------------------------------------------------------------
    // Cleared only once the queue has drained, so queued words finish
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shifter_on_q <= 1'b0;
        else if (shift_start)
            shifter_on_q <= 1'b1;
        else if (cnt_q == 5'h00)
            shifter_on_q <= 1'b0;
    end

    // --------------------------------------------------------------
    // FIFO storage
    // --------------------------------------------------------------
    // Upper bits above the length are stored but never shifted
    always_ff @(posedge pclk)
    begin
        if (push)
            fifo_mem[wr_ptr_q] <= pwdata[15:0];
    end

    // --------------------------------------------------------------
    // Pointers, count and bit index
    // --------------------------------------------------------------
    // Pointers wrap at the live depth; a wrap empties the queue
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_q  <= 4'h0;
            rd_ptr_q  <= 4'h0;
            cnt_q     <= 5'h00;
            bit_idx_q <= 4'h0;
        end
        else
        begin
            cnt_q <= cnt_d;
            if (wrap)
            begin
                wr_ptr_q  <= 4'h0;
                rd_ptr_q  <= 4'h0;
                bit_idx_q <= poly_len_minus_one;
            end
            else
            begin
                if (push)
                    wr_ptr_q <= ((5'(wr_ptr_q) + 5'h01) == depth) ? 4'h0
                                                                  : wr_ptr_q + 4'h1;
                if (pop)
                    rd_ptr_q <= ((5'(rd_ptr_q) + 5'h01) == depth) ? 4'h0
                                                                  : rd_ptr_q + 4'h1;
                if (!shifter_on_q || empty_now || pop)
                    bit_idx_q <= poly_len_minus_one;
                else if (shift_en)
                    bit_idx_q <= bit_idx_q - 4'h1;
            end
        end
    end

    // --------------------------------------------------------------
    // Status and event outputs
    // --------------------------------------------------------------
    // Event is a one-cycle pulse; a wrap never produces it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            crc_event       <= 1'b0;
            fifo_full_flag  <= 1'b0;
            fifo_empty_flag <= 1'b1;
        end
        else
        begin
            crc_event       <= (cnt_q == 5'h01) && (cnt_d == 5'h00) && !wrap;
            fifo_full_flag  <= (cnt_d == depth);
            fifo_empty_flag <= (cnt_d == 5'h00);
        end
    end

    // --------------------------------------------------------------
    // CRC engine
    // --------------------------------------------------------------
    pcrc_shifter pcrc_shifter_i (
        .pclk                (pclk),
        .presetn             (presetn),
        .shift_en            (shift_en),
        .din                 (cur_bit),
        .seed_load           (wr_seed),
        .seed                (pwdata[15:0]),
        .poly_len_minus_one  (poly_len_minus_one),
        .crc_polynomial_taps (crc_polynomial_taps),
        .crc_q               (crc_q)
    );

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    // One clock domain, so every property shares these defaults
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Count bookkeeping: wraps, pushes and pops
    count_wrap_a: assert property (wrap |=> cnt_q == 5'h00 && !crc_event)
        else $error("write while full did not wrap the count");
    push_inc_a: assert property (push && !pop |=> cnt_q == $past(cnt_q) + 5'h01)
        else $error("write did not raise the count");
    pop_dec_a: assert property (pop && !push && !wrap |=> cnt_q == $past(cnt_q) - 5'h01)
        else $error("finished word did not lower the count");
    depth_cap_a: assert property (cnt_q <= depth || $changed(poly_len_minus_one))
        else $error("count above FIFO depth");

    // Event only on a one-to-zero drain, and one cycle long
    event_cause_a: assert property (crc_event |-> cnt_q == 5'h00 && $past(cnt_q) == 5'h01)
        else $error("event without a one-to-zero count change");
    event_seen_a: assert property (pop && cnt_q == 5'h01 && !push && !wrap |=> crc_event)
        else $error("last word drained without an event");
    event_pulse_a: assert property (crc_event |=> !crc_event)
        else $error("event held for more than one cycle");

    // Flags are registered from the next count, so they match cnt_q in the same cycle
    full_flag_a: assert property (##1 fifo_full_flag == (cnt_q == depth))
        else $error("full flag disagrees with count");
    empty_flag_a: assert property (##1 fifo_empty_flag == (cnt_q == 5'h00))
        else $error("empty flag disagrees with count");

    // Shifter gating; clearing start must not strand queued words
    shift_gate_a: assert property (shift_en |-> cnt_q != 5'h00 && shifter_on_q)
        else $error("shifting with empty FIFO or shifter off");
    stop_hold_a: assert property (!shift_start && !empty_now |=> $stable(shifter_on_q))
        else $error("shifter stopped with words queued");
    crc_hold_a: assert property (!shift_en && !wr_seed |=> $stable(crc_q))
        else $error("crc changed without a shift");
    sleep_stop_a: assert property (sleep_mode |-> !shift_en)
        else $error("shifting while asleep");
    idle_stop_a: assert property (idle_mode && stop_in_idle |-> !shift_en)
        else $error("shifting in idle with stop_in_idle set");
    // Seed and length writes stay legal while suspended, so they are exempt
    freeze_a: assert property (
        !run_en && !wrap && !wr_seed && !wr_ctl |=> $stable(bit_idx_q) && $stable(crc_q))
        else $error("shifter moved while suspended");

    // Bit timing: one bit per clock, length+1 clocks per word
    word_len_a: assert property (
        pop |-> bit_idx_q == 4'h0 && $past(bit_idx_q) == 4'h1 || poly_len_minus_one == 4'h0)
        else $error("word length out of step with length field");
    bit_step_a: assert property (
        shift_en && !pop && !wrap |=> bit_idx_q + 4'h1 == $past(bit_idx_q))
        else $error("bit index skipped or stalled while shifting");

    // Register fields
    taps_bit0_a: assert property (crc_polynomial_taps[0] == 1'b0)
        else $error("tap bit 0 holds a one");
    len_write_a: assert property (
        wr_ctl && pstrb[0] |=> poly_len_minus_one == $past(pwdata[3:0]))
        else $error("length field did not take the written value");

    // Main scenarios worth seeing in a run
    wrap_c:      cover property (wrap);
    event_c:     cover property (crc_event);
    full_c:      cover property (fifo_full_flag && shift_en);
    suspend_c:   cover property (!run_en && shifter_on_q && !empty_now);
    long_full_c: cover property (fifo_full_flag && poly_len_minus_one > PLEN_SHORT);
endmodule // pcrc_top

// ===== rtl/pcrc_pkg.sv
package pcrc_pkg;
    // --------------------------------------------------------------
    // Register map (byte addresses on APB)
    // --------------------------------------------------------------
    localparam logic [7:0]  ADDR_CONTROL = 8'h00;
    localparam logic [7:0]  ADDR_TAPS    = 8'h04;
    localparam logic [7:0]  ADDR_DATA    = 8'h08;
    localparam logic [7:0]  ADDR_SEED    = 8'h0C;

    // --------------------------------------------------------------
    // Control register fields
    // --------------------------------------------------------------
    localparam int          CTL_PLEN_LSB = 0;
    localparam int          CTL_GO_BIT   = 4;
    localparam int          CTL_EMPTY    = 6;
    localparam int          CTL_FULL     = 7;
    localparam int          CTL_CNT_LSB  = 8;
    localparam int          CTL_IDLE_BIT = 13;

    // --------------------------------------------------------------
    // Reset values and FIFO sizing
    // --------------------------------------------------------------
    localparam logic [3:0]  PLEN_RST     = 4'h0;
    localparam logic [15:0] TAPS_RST     = 16'h0000;
    localparam logic [15:0] SEED_RST     = 16'h0000;
    localparam logic [3:0]  PLEN_SHORT   = 4'h7;
    localparam logic [4:0]  DEPTH_LONG   = 5'h08;
    localparam logic [4:0]  DEPTH_SHORT  = 5'h10;
    localparam logic [15:0] TAPS_MASK    = 16'hFFFE;
endpackage

// ===== rtl/pcrc_shifter.sv
`timescale 1ns/1ps
module pcrc_shifter
    import pcrc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        shift_en,
    input  wire logic        din,
    input  wire logic        seed_load,
    input  wire logic [15:0] seed,
    input  wire logic [3:0]  poly_len_minus_one,
    input  wire logic [15:0] crc_polynomial_taps,
    output logic      [15:0] crc_q
);
    // --------------------------------------------------------------
    // One step of the programmable LFSR
    // --------------------------------------------------------------
    // Top stage is crc[len]; its feedback closes the implicit top term
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic        d,
                                             input logic [3:0]  len,
                                             input logic [15:0] taps);
        logic [15:0] n;
        logic        fb;
        fb = c[len] ^ d;
        n  = 16'h0000;
        n[0] = fb;
        for (int i = 1; i < 16; i++)
        begin
            if (i <= int'(len))
                n[i] = c[i-1] ^ (taps[i] & fb);
        end
        return n;
    endfunction

    logic [15:0] crc_d;

    // Seed load outranks shifting; bits above the length stay zero
    assign crc_d = seed_load ? (seed & ((16'h0002 << poly_len_minus_one) - 16'h0001))
                 : crc_step(crc_q, din, poly_len_minus_one, crc_polynomial_taps);

    // CRC register, one input bit per enabled clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            crc_q <= SEED_RST;
        else if (seed_load || shift_en)
            crc_q <= crc_d;
    end
endmodule // pcrc_shifter

// ===== sim/pcrc_top_bench.sv
`timescale 1ns/1ps
module pcrc_top_bench;
    import pcrc_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic        sleep_mode;
    logic        idle_mode;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        crc_event;
    logic        fifo_full_flag;
    logic        fifo_empty_flag;
    logic [31:0] rd;
    logic        err;
    logic [15:0] crc;
    int          fails;
    int          checked;
    int          events;
    int          n1;
    int          n2;

    // ----------------------------------------------------------------
    // Design under test
    // ----------------------------------------------------------------
    pcrc_top pcrc_top_i (
        .pclk            (pclk),
        .presetn         (presetn),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .pstrb           (pstrb),
        .sleep_mode      (sleep_mode),
        .idle_mode       (idle_mode),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .crc_event       (crc_event),
        .fifo_full_flag  (fifo_full_flag),
        .fifo_empty_flag (fifo_empty_flag)
    );

    // ----------------------------------------------------------------
    // Clock and event monitor
    // ----------------------------------------------------------------
    // Free-running 125 MHz clock
    always #4 pclk = ~pclk;

    // Count event pulses; each one lasts a single cycle
    always @(posedge pclk)
        if (presetn === 1'b1 && crc_event === 1'b1)
            events <= events + 1;

    // ----------------------------------------------------------------
    // Checks and reference model
    // ----------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: %s got %b expected %b", $time, m, got, exp);
        end
    endtask

    // Bit-serial reference: top bit first, feedback from the top stage
    function automatic logic [15:0] crc_next(logic [15:0] c, logic [15:0] w, int len,
                                             logic [15:0] t);
        logic fb;
        for (int b = len; b >= 0; b--)
        begin
            fb = c[len] ^ w[b];
            for (int n = len; n >= 1; n--)
                c[n] = c[n-1] ^ (t[n] & fb);
            c[0] = fb;
        end
        return c;
    endfunction

    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    // Setup then access; the master never assumes a fixed wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk_bit(pready, 1'b1, "pready");
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, a, d, s);
    endtask

    task automatic rreg(input logic [7:0] a);
        apb(1'b0, a, 32'h0, 4'h0);
    endtask

    // Bounded wait for the FIFO to drain, counting cycles
    task automatic wait_empty(output int n);
        n = 0;
        while (fifo_empty_flag !== 1'b1 && n < 500)
        begin
            @(posedge pclk);
            n++;
        end
        chk_bit(fifo_empty_flag, 1'b1, "drain");
    endtask

    // Start the shifter, optionally clearing start again at once
    task automatic run(input logic [31:0] ctl, input bit stop, output int n);
        wreg(ADDR_CONTROL, ctl | 32'h10, 4'h3);
        if (stop)
            wreg(ADDR_CONTROL, ctl, 4'h3);
        wait_empty(n);
    endtask

    task report_and_stop;
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    // Watchdog sized well above the few hundred cycles the tests need
    initial
    begin
        #100000;
        fails++;
        report_and_stop();
    end

    initial
    begin
        pclk       = 1'b0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        pstrb      = 4'h0;
        sleep_mode = 1'b0;
        idle_mode  = 1'b0;
        fails      = 0;
        checked    = 0;
        events     = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rreg(ADDR_CONTROL);
        chk_word(rd, 32'h40, "control reset");
        chk_bit(fifo_full_flag, 1'b0, "full reset");
        rreg(ADDR_TAPS);
        chk_word(rd, 32'h0, "taps reset");
        wreg(ADDR_TAPS, 32'hFFFF, 4'h3);
        rreg(ADDR_TAPS);
        chk_word(rd, 32'hFFFE, "taps bit 0");
        rreg(8'h10);
        chk_bit(err, 1'b1, "unmapped error");
        chk_word(rd, 32'h0, "unmapped data");
        // Idle with stop_in_idle clear must not slow anything down
        idle_mode <= 1'b1;
        wreg(ADDR_TAPS, 32'h0006, 4'h3);
        wreg(ADDR_SEED, 32'h0, 4'h3);
        wreg(ADDR_CONTROL, 32'h07, 4'h1);
        wreg(ADDR_DATA, 32'hA5, 4'h1);
        run(32'h07, 1'b0, n1);
        rreg(ADDR_DATA);
        crc = crc_next(16'h0, 16'hA5, 7, 16'h0006);
        chk_word(rd, {16'h0, crc}, "crc one word");
        // Stop the shifter first so the words queue up before the start
        wreg(ADDR_CONTROL, 32'h07, 4'h3);
        wreg(ADDR_SEED, 32'h0, 4'h3);
        wreg(ADDR_DATA, 32'hFF3C, 4'h1);
        wreg(ADDR_DATA, 32'h5A, 4'h1);
        run(32'h07, 1'b0, n2);
        chk_word(32'(n2 - n1), 32'h8, "cycles per word");
        rreg(ADDR_DATA);
        crc = crc_next(crc_next(16'h0, 16'h3C, 7, 16'h0006), 16'h5A, 7, 16'h0006);
        chk_word(rd, {16'h0, crc}, "crc two words");
        chk_word(32'(events), 32'h2, "one event per drain");
        idle_mode <= 1'b0;
        // Clearing start mid-run still finishes the queued words
        wreg(ADDR_CONTROL, 32'h07, 4'h3);
        wreg(ADDR_SEED, 32'h0, 4'h3);
        wreg(ADDR_DATA, 32'h11, 4'h1);
        wreg(ADDR_DATA, 32'h22, 4'h1);
        run(32'h07, 1'b1, n1);
        rreg(ADDR_DATA);
        crc = crc_next(crc_next(16'h0, 16'h11, 7, 16'h0006), 16'h22, 7, 16'h0006);
        chk_word(rd, {16'h0, crc}, "crc after stop");
        // Fill to depth, then overflow, for both length ranges
        for (int i = 0; i < 16; i++)
            wreg(ADDR_DATA, 32'(i), 4'h1);
        // The flag is launched at the last write's edge; look one edge on
        @(posedge pclk);
        chk_bit(fifo_full_flag, 1'b1, "full short");
        rreg(ADDR_CONTROL);
        chk_word({27'h0, rd[12:8]}, 32'h10, "count short");
        wreg(ADDR_DATA, 32'h77, 4'h1);
        rreg(ADDR_CONTROL);
        chk_word({16'h0, rd[15:0]}, 32'h47, "wrap short");
        wreg(ADDR_CONTROL, 32'h0F, 4'h1);
        wreg(ADDR_DATA, 32'h1234, 4'h1);
        rreg(ADDR_CONTROL);
        chk_word({27'h0, rd[12:8]}, 32'h0, "top lane missing");
        for (int i = 0; i < 8; i++)
            wreg(ADDR_DATA, 32'h1234, 4'h3);
        @(posedge pclk);
        chk_bit(fifo_full_flag, 1'b1, "full long");
        rreg(ADDR_CONTROL);
        chk_word({16'h0, rd[15:0]}, 32'h088F, "count long");
        wreg(ADDR_DATA, 32'h1234, 4'h3);
        rreg(ADDR_CONTROL);
        chk_word({16'h0, rd[15:0]}, 32'h4F, "wrap long");
        chk_word(32'(events), 32'h3, "no event on wrap");
        // Sleep, then idle with stop_in_idle set, must both freeze
        for (int m = 0; m < 2; m++)
        begin
            wreg(ADDR_CONTROL, (m == 1) ? 32'h2007 : 32'h07, 4'h3);
            wreg(ADDR_DATA, 32'h99, 4'h1);
            if (m == 0)
                sleep_mode <= 1'b1;
            else
                idle_mode <= 1'b1;
            wreg(ADDR_CONTROL, (m == 1) ? 32'h2017 : 32'h17, 4'h3);
            repeat (40) @(posedge pclk);
            rreg(ADDR_CONTROL);
            chk_word({27'h0, rd[12:8]}, 32'h1, "frozen count");
            sleep_mode <= 1'b0;
            idle_mode  <= 1'b0;
            wait_empty(n1);
        end
        repeat (2) @(posedge pclk);
        chk_word(32'(events), 32'h5, "events after resume");
        report_and_stop();
    end
endmodule // pcrc_top_bench
